// [rtl/pio_pkg.sv]
package pio_pkg;

   // Register word offsets (byte addresses within the peripheral region).
   localparam logic [15:0] PIO_OFS_DIRECTION = 16'h6140;
   localparam logic [15:0] PIO_OFS_LEVEL = 16'h6150;
   localparam logic [15:0] PIO_OFS_LATCH = 16'h6160;
   localparam logic [15:0] PIO_OFS_OPEN_DRAIN = 16'h6170;
   localparam logic [15:0] PIO_OFS_ANALOG_SEL = 16'h6180;
   localparam logic [15:0] PIO_OFS_CHANGE_EN = 16'h6190;
   localparam logic [15:0] PIO_OFS_PULLUP_EN = 16'h61A0;
   localparam logic [15:0] PIO_OFS_CHANGE_PEND = 16'h61B0;
   localparam logic [15:0] PIO_OFS_CTRL = 16'h61C0;

   // Alias offsets added to a base register address.
   localparam logic [3:0] PIO_ALIAS_BASE = 4'h0;
   localparam logic [3:0] PIO_ALIAS_CLR = 4'h4;
   localparam logic [3:0] PIO_ALIAS_SET = 4'h8;
   localparam logic [3:0] PIO_ALIAS_INV = 4'hC;

   // Implemented pins and reset values of the bank.
   localparam logic [15:0] PIO_IMPL_MASK = 16'h313F;
   localparam logic [15:0] PIO_DIRECTION_RST = 16'h313F;
   localparam logic [15:0] PIO_OPEN_DRAIN_RST = 16'h0000;
   localparam logic [15:0] PIO_ANALOG_SEL_RST = 16'h0000;
   localparam logic [15:0] PIO_ANALOG_CAPABLE = 16'h0003;
   localparam logic [15:0] PIO_CHANGE_CAPABLE = 16'h0030;
   localparam logic [15:0] PIO_REF_OUT_PIN = 16'h0004;
   localparam logic [15:0] PIO_ZERO_RST = 16'h0000;

   // Control register field positions.
   localparam int PIO_CTRL_REF_OUT_BIT = 0;

   // Register selector indices.
   typedef enum logic [3:0] {
      PIO_R_DIR = 4'h0,
      PIO_R_LVL = 4'h1,
      PIO_R_LAT = 4'h2,
      PIO_R_ODC = 4'h3,
      PIO_R_ANA = 4'h4,
      PIO_R_CEN = 4'h5,
      PIO_R_PUE = 4'h6,
      PIO_R_PND = 4'h7,
      PIO_R_CTL = 4'h8,
      PIO_R_NONE = 4'hF
   } pio_reg_t;

endpackage

// [rtl/pio_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of pin inputs.
module pio_sync #(
   parameter int W = 16
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Data.
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   // The first stage is read by the second stage only.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule

// [rtl/pio_bank.sv]
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// - Direction one makes pin input, zero drives the latch value.
// - After reset every implemented pin is an input.
// - Level register reads sensed pins; writes go to the latch.
// - Latch register reads last value written via latch or level.
// - Unimplemented pin bits read zero in direction, level and latch.
// - Clear, set, invert aliases modify only bits written as one.
// - Alias reads return undefined data; here they return zero.
// - Aliases decode at base plus 0x4, 0x8 and 0xC.
// - Direction, level, latch, open-drain at 16-byte steps from 0x6140.
// - Reset loads direction ones and open-drain zeros.
// - Analog select one means digital, zero analog; resets to zero.
// - Analog pins have digital input off and level bit reads zero.
// - Open-drain output drives low only, floats for high.
// - Enabled reference output appears on its pin regardless of direction.
// - Any enabled change-notice pin change raises the change request.
// - Weak pull-up enabled only while its enable bit is set.
module pio_bank
   import pio_pkg::*;
#(
   parameter int NPINS = 16
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Port pins.
   input wire logic [NPINS-1:0] pin_i,
   output logic [NPINS-1:0] pin_o,
   output logic [NPINS-1:0] pin_oe_o,
   // Analog and pull-up controls toward the pad ring.
   output logic [NPINS-1:0] analog_en_o,
   output logic [NPINS-1:0] pullup_en_o,
   output logic ref_out_en_o,
   // Change notification request.
   output logic change_req_o
);

   // The bank layout is fixed at sixteen pins.
   initial begin
      if (NPINS != 16) begin
         $error("pio_bank supports exactly 16 pins");
      end
   end

   logic [15:0] direction;
   logic [15:0] latch;
   logic [15:0] open_drain;
   logic [15:0] analog_sel;
   logic [15:0] change_en;
   logic [15:0] pullup_en;
   logic [15:0] change_pend;
   logic ref_out_en;
   logic [15:0] sync_pins;
   logic [15:0] prev_pins;
   logic prev_valid;

   // Update of a base register from a base or alias write.
   function automatic logic [15:0] apply_op(input logic [15:0] cur, input logic [15:0] wd,
                                            input logic [3:0] op);
      logic [15:0] r;
      r = cur;
      unique case (op)
         PIO_ALIAS_BASE: r = wd;
         PIO_ALIAS_CLR: r = cur & ~wd;
         PIO_ALIAS_SET: r = cur | wd;
         PIO_ALIAS_INV: r = cur ^ wd;
         default: r = cur;
      endcase
      return r;
   endfunction

   // Pin inputs are synchronised before any logic reads them.
   pio_sync #(
      .W(16)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pin_i),
      .q_o(sync_pins)
   );

   // Address decode: the high bits pick the register, the low nibble the alias.
   wire logic [3:0] alias_op = wb_adr_i[3:0];
   wire logic [11:0] reg_base = wb_adr_i[15:4];
   wire logic alias_legal = (alias_op == PIO_ALIAS_BASE) || (alias_op == PIO_ALIAS_CLR)
                            || (alias_op == PIO_ALIAS_SET) || (alias_op == PIO_ALIAS_INV);
   wire pio_reg_t reg_sel =
      !alias_legal ? PIO_R_NONE :
      (reg_base == PIO_OFS_DIRECTION[15:4]) ? PIO_R_DIR :
      (reg_base == PIO_OFS_LEVEL[15:4]) ? PIO_R_LVL :
      (reg_base == PIO_OFS_LATCH[15:4]) ? PIO_R_LAT :
      (reg_base == PIO_OFS_OPEN_DRAIN[15:4]) ? PIO_R_ODC :
      (reg_base == PIO_OFS_ANALOG_SEL[15:4]) ? PIO_R_ANA :
      (reg_base == PIO_OFS_CHANGE_EN[15:4]) ? PIO_R_CEN :
      (reg_base == PIO_OFS_PULLUP_EN[15:4]) ? PIO_R_PUE :
      (reg_base == PIO_OFS_CHANGE_PEND[15:4]) ? PIO_R_PND :
      (reg_base == PIO_OFS_CTRL[15:4]) ? PIO_R_CTL : PIO_R_NONE;

   // A request is taken once; ack is dropped the cycle after it is given.
   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic wr = req && wb_we_i;
   wire logic [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   // Byte lanes not selected are zeroed in the operand; upd keeps their current bits through the lane mask.
   wire logic [15:0] wbase = (wb_dat_i[15:0] & lane_mask);

   function automatic logic [15:0] upd(input logic [15:0] cur, input logic [15:0] wd,
                                       input logic [3:0] op, input logic [15:0] m);
      logic [15:0] r;
      r = apply_op(cur, wd, op);
      return (r & m) | (cur & ~m);
   endfunction

   // Digital view of the pins: analog-selected pins read zero.
   wire logic [15:0] digital_mask = analog_sel | ~PIO_ANALOG_CAPABLE;
   wire logic [15:0] level_view = sync_pins & digital_mask & PIO_IMPL_MASK;
   wire logic [15:0] change_hit = (level_view ^ prev_pins) & change_en & {16{prev_valid}};

   // Next values of the software registers.
   wire logic lat_wr = wr && (reg_sel == PIO_R_LAT || reg_sel == PIO_R_LVL);
   wire logic [15:0] next_latch = upd(latch, wbase, alias_op, lane_mask) & PIO_IMPL_MASK;
   wire logic [15:0] next_dir = upd(direction, wbase, alias_op, lane_mask) & PIO_IMPL_MASK;
   wire logic [15:0] next_odc = upd(open_drain, wbase, alias_op, lane_mask) & PIO_IMPL_MASK;
   wire logic [15:0] next_ana = upd(analog_sel, wbase, alias_op, lane_mask);
   wire logic [15:0] next_cen = upd(change_en, wbase, alias_op, lane_mask) & PIO_CHANGE_CAPABLE;
   wire logic [15:0] next_pue = upd(pullup_en, wbase, alias_op, lane_mask) & PIO_CHANGE_CAPABLE;
   wire logic [15:0] pnd_sw = upd(change_pend, wbase, alias_op, lane_mask);
   // Hardware sets win over a clear in the same cycle.
   wire logic [15:0] next_pend = ((wr && reg_sel == PIO_R_PND) ? pnd_sw : change_pend)
                                 | change_hit;
   wire logic [15:0] ctl_cur = {15'h0000, ref_out_en};
   wire logic [15:0] next_ctl = upd(ctl_cur, wbase, alias_op, lane_mask);

   // Configuration registers; direction comes up as all inputs.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         direction <= PIO_DIRECTION_RST;
         open_drain <= PIO_OPEN_DRAIN_RST;
         analog_sel <= PIO_ANALOG_SEL_RST;
         change_en <= PIO_ZERO_RST;
         pullup_en <= PIO_ZERO_RST;
         ref_out_en <= 1'b0;
      end else if (wr) begin
         if (reg_sel == PIO_R_DIR) direction <= next_dir;
         if (reg_sel == PIO_R_ODC) open_drain <= next_odc;
         if (reg_sel == PIO_R_ANA) analog_sel <= next_ana;
         if (reg_sel == PIO_R_CEN) change_en <= next_cen;
         if (reg_sel == PIO_R_PUE) pullup_en <= next_pue;
         if (reg_sel == PIO_R_CTL) ref_out_en <= next_ctl[PIO_CTRL_REF_OUT_BIT];
      end
   end

   // The latch has no documented reset value; zero is chosen so pins never float unknown.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch <= PIO_ZERO_RST;
      end else if (lat_wr) begin
         latch <= next_latch;
      end
   end

   // Change detection against the previous sampled value.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_pins <= PIO_ZERO_RST;
         prev_valid <= 1'b0;
         change_pend <= PIO_ZERO_RST;
         change_req_o <= 1'b0;
      end else begin
         prev_pins <= level_view;
         prev_valid <= 1'b1;
         change_pend <= next_pend;
         change_req_o <= |next_pend;
      end
   end

   // Pad drive: open-drain pins only ever drive low; the reference pin is released.
   wire logic [15:0] drive_out = ~direction & PIO_IMPL_MASK;
   wire logic [15:0] od_release = open_drain & latch;
   wire logic [15:0] ref_mask = ref_out_en ? PIO_REF_OUT_PIN : 16'h0000;
   wire logic [15:0] next_oe = drive_out & ~od_release & ~ref_mask;
   wire logic [15:0] next_pin = latch & ~open_drain;

   // Read mux; alias reads return zero.
   wire logic [15:0] rd_base =
      (reg_sel == PIO_R_DIR) ? direction :
      (reg_sel == PIO_R_LVL) ? level_view :
      (reg_sel == PIO_R_LAT) ? latch :
      (reg_sel == PIO_R_ODC) ? open_drain :
      (reg_sel == PIO_R_ANA) ? analog_sel :
      (reg_sel == PIO_R_CEN) ? change_en :
      (reg_sel == PIO_R_PUE) ? pullup_en :
      (reg_sel == PIO_R_PND) ? change_pend :
      (reg_sel == PIO_R_CTL) ? ctl_cur : 16'h0000;
   wire logic [15:0] rd_data = (alias_op == PIO_ALIAS_BASE) ? rd_base : 16'h0000;

   // Bus answer one cycle after the strobe; unmapped addresses ack with zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? {16'h0000, rd_data} : 32'h0000_0000;
      end
   end

   // Registered pad controls.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o <= '0;
         pin_oe_o <= '0;
         analog_en_o <= PIO_ANALOG_CAPABLE;
         pullup_en_o <= '0;
         ref_out_en_o <= 1'b0;
      end else begin
         pin_o <= next_pin;
         pin_oe_o <= next_oe;
         analog_en_o <= ~analog_sel & PIO_ANALOG_CAPABLE;
         pullup_en_o <= pullup_en;
         ref_out_en_o <= ref_out_en;
      end
   end

   // Checks.
   sequence s_wr_dir;
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && reg_sel == PIO_R_DIR;
   endsequence

   a_input_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      direction[0] |-> ##1 !pin_oe_o[0]) else $error("input pin driven");
   a_reset_inputs: assert property (@(posedge clk_i)
      $fell(rst_i) |-> direction == PIO_DIRECTION_RST) else $error("reset dir");
   a_level_to_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && reg_sel == PIO_R_LVL && alias_op == PIO_ALIAS_BASE && wb_sel_i[1:0] == 2'b11)
      |=> latch == ($past(wb_dat_i[15:0]) & PIO_IMPL_MASK)) else $error("latch");
   a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      ((direction | latch) & ~PIO_IMPL_MASK) == 16'h0000) else $error("unimpl");
   a_alias_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_wr_dir and (alias_op == PIO_ALIAS_SET && wb_sel_i[1:0] == 2'b11))
      |=> direction == (($past(direction) | $past(wb_dat_i[15:0])) & PIO_IMPL_MASK))
      else $error("set alias");
   a_alias_rd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && alias_op != PIO_ALIAS_BASE) |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
      else $error("alias read");
   a_analog_reads0: assert property (@(posedge clk_i) disable iff (rst_i)
      (level_view & ~analog_sel & PIO_ANALOG_CAPABLE) == 16'h0000)
      else $error("analog read");
   a_od_no_high: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 (pin_oe_o & pin_o & $past(open_drain)) == 16'h0000) else $error("od high");
   a_change_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (|change_hit) |=> (change_req_o && (change_pend & $past(change_hit)) == $past(change_hit)))
      else $error("change lost");
   a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack held");

endmodule

// [bench/pio_board.sv]
`timescale 1ns/1ps
// Board circuitry on the port pins: an outside driver per pin, else the weak pull-up.
module pio_board (
   // Clock.
   input wire logic clk_i,
   // Pad controls from the bank.
   input wire logic [15:0] pin_o_i,
   input wire logic [15:0] oe_i,
   input wire logic [15:0] pullup_i,
   // Outside drivers set by the bench.
   input wire logic [15:0] ext_val_i,
   input wire logic [15:0] ext_en_i,
   // Resolved pin levels.
   output logic [15:0] level_o
);
   logic [15:0] float_q = 16'h5555;

   // A released line with no pull-up keeps changing, so no stale value is read.
   always @(posedge clk_i) begin
      float_q <= ~float_q;
   end

   // The bank's driver wins, then an outside driver, then the pull-up.
   assign level_o = (oe_i & pin_o_i) | (~oe_i & ext_en_i & ext_val_i)
      | (~oe_i & ~ext_en_i & (pullup_i | float_q));
endmodule

// [bench/parallel_io_port_bank_tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the port bank; reads are checked from a queue by a monitor.
module parallel_io_port_bank_tb;
   import pio_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [15:0] wb_adr_i = 16'h0000, ext_val = 16'h0000, ext_en = 16'hFFFF, lvl, mdl, m;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, exp_q[$], seed = 32'h0000_5FE7;
   logic wb_ack_o, ref_out_en_o, change_req_o;
   logic [15:0] pin_o, pin_oe_o, analog_en_o, pullup_en_o;
   logic [15:0] bases [3] = '{PIO_OFS_DIRECTION, PIO_OFS_LATCH, PIO_OFS_OPEN_DRAIN};
   logic [3:0] ops [3] = '{PIO_ALIAS_CLR, PIO_ALIAS_SET, PIO_ALIAS_INV};
   int mismatches = 0, n_compared = 0;

   pio_bank #(.NPINS(16)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(lvl),
      .pin_o(pin_o), .pin_oe_o(pin_oe_o), .analog_en_o(analog_en_o),
      .pullup_en_o(pullup_en_o), .ref_out_en_o(ref_out_en_o), .change_req_o(change_req_o));
   pio_board board (.clk_i(clk_i), .pin_o_i(pin_o), .oe_i(pin_oe_o), .pullup_i(pullup_en_o),
      .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(lvl));

   // The clock toggles every 2 ns, a half period of the 4 ns clock.
   initial begin
      forever #2 clk_i = ~clk_i;
   end

   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One classic cycle; the request is held until ack is sampled high.
   task automatic wb(input logic we, input logic [15:0] adr, input logic [15:0] dat,
                     input logic [15:0] want);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'h3;
      wb_dat_i <= {16'h0000, dat};
      if (!we) exp_q.push_back({16'h0000, want});
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) mismatches++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] adr, input logic [15:0] dat);
      wb(1'b1, adr, dat, 16'h0000);
   endtask

   task automatic rd(input logic [15:0] adr, input logic [15:0] want);
      wb(1'b0, adr, 16'h0000, want);
   endtask

   // Let pin changes cross the synchroniser, then sample off the edge.
   task automatic settle(input logic [15:0] v);
      @(posedge clk_i);
      ext_val <= v;
      repeat (5) @(posedge clk_i);
      #1;
   endtask

   // Monitor: each acknowledged read takes the oldest expected value.
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         if (exp_q.size() == 0) mismatches++;
         else check(wb_dat_o, exp_q.pop_front());
      end
   end

   // Watchdog well beyond the few hundred cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      finish_test();
   end

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check(pin_oe_o, 16'h0000);
      check(analog_en_o, PIO_ANALOG_CAPABLE);
      rd(PIO_OFS_DIRECTION, PIO_DIRECTION_RST);
      rd(PIO_OFS_OPEN_DRAIN, PIO_OPEN_DRAIN_RST);
      rd(16'h6141, 16'h0000);
      rd(16'h7000, 16'h0000);
      $display("Reset values done");
      // Aliases on the direction, latch and open-drain registers, with a running model of the bits.
      foreach (bases[r]) begin
         mdl = rnd();
         wr(bases[r], mdl);
         mdl &= PIO_IMPL_MASK;
         foreach (ops[o]) begin
            m = rnd();
            wr({bases[r][15:4], ops[o]}, m);
            if (o == 0) mdl &= ~m;
            else if (o == 1) mdl |= m & PIO_IMPL_MASK;
            else mdl ^= m & PIO_IMPL_MASK;
            rd(bases[r], mdl);
            rd({bases[r][15:4], ops[o]}, 16'h0000);
         end
      end
      wr(PIO_OFS_DIRECTION, PIO_DIRECTION_RST);
      wr(PIO_OFS_OPEN_DRAIN, 16'h0000);
      $display("Aliases done");
      m = rnd();
      settle(m);
      rd(PIO_OFS_LEVEL, m & PIO_IMPL_MASK & ~PIO_ANALOG_CAPABLE);
      wr(PIO_OFS_ANALOG_SEL, PIO_ANALOG_CAPABLE);
      m = rnd();
      settle(m);
      check(analog_en_o, 16'h0000);
      rd(PIO_OFS_LEVEL, m & PIO_IMPL_MASK);
      $display("Inputs done");
      mdl = rnd();
      wr(PIO_OFS_LEVEL, mdl);
      mdl &= PIO_IMPL_MASK;
      wr(PIO_OFS_DIRECTION, 16'h0000);
      settle(~m);
      check(pin_oe_o, PIO_IMPL_MASK);
      check(pin_o & PIO_IMPL_MASK, mdl);
      rd(PIO_OFS_LEVEL, mdl);
      wr({PIO_OFS_LEVEL[15:4], PIO_ALIAS_INV}, 16'h0001);
      mdl ^= 16'h0001;
      rd(PIO_OFS_LATCH, mdl);
      m = rnd() & PIO_IMPL_MASK;
      wr(PIO_OFS_OPEN_DRAIN, m);
      settle(16'h0000);
      check(pin_oe_o, PIO_IMPL_MASK & ~(m & mdl));
      check(pin_o & pin_oe_o & m, 16'h0000);
      wr(PIO_OFS_CTRL, 16'h0001);
      settle(16'h0000);
      check(ref_out_en_o, 1'b1);
      check(pin_oe_o & PIO_REF_OUT_PIN, 16'h0000);
      wr(PIO_OFS_CTRL, 16'h0000);
      wr(PIO_OFS_DIRECTION, PIO_DIRECTION_RST);
      wr(PIO_OFS_OPEN_DRAIN, 16'h0000);
      $display("Outputs done");
      wr(PIO_OFS_CHANGE_EN, PIO_CHANGE_CAPABLE);
      settle(16'h0000);
      wr({PIO_OFS_CHANGE_PEND[15:4], PIO_ALIAS_CLR}, 16'hFFFF);
      settle(16'h0008);
      check(change_req_o, 1'b0);
      settle(16'h0018);
      check(change_req_o, 1'b1);
      settle(16'h0008);
      check(change_req_o, 1'b1);
      rd(PIO_OFS_CHANGE_PEND, 16'h0010);
      wr({PIO_OFS_CHANGE_PEND[15:4], PIO_ALIAS_CLR}, 16'h0010);
      settle(16'h0008);
      check(change_req_o, 1'b0);
      wr(PIO_OFS_PULLUP_EN, 16'h0020);
      settle(16'h0008);
      check(pullup_en_o, 16'h0020);
      wr({PIO_OFS_PULLUP_EN[15:4], PIO_ALIAS_CLR}, 16'h0020);
      settle(16'h0008);
      check(pullup_en_o, 16'h0000);
      $display("Change notice done");
      wr(PIO_OFS_DIRECTION, 16'h0000);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check(pin_oe_o, 16'h0000);
      rd(PIO_OFS_DIRECTION, PIO_DIRECTION_RST);
      $display("Second reset done");
      finish_test();
   end
endmodule
